// >>> verilog/bcp_regs.svh
// Purpose: field positions, reset values and timing counts
// Assumes: 100 MHz system clock
// Notes:   times in ms are counted on a 1 ms prescaler tick
`ifndef BCP_REGS_SVH
`define BCP_REGS_SVH
// ==========================================
// clock and timing
`define BCP_CLK_MHZ           100
`define BCP_T_MS_US           1000
`define BCP_MS_CYC            (`BCP_T_MS_US * `BCP_CLK_MHZ)
`define BCP_T_PROBE_US        27
`define BCP_PROBE_CYC         (`BCP_T_PROBE_US * `BCP_CLK_MHZ)
`define BCP_T_DQ_LOW_MS       2000
`define BCP_T_WIND_MS         11000
`define BCP_T_CONV_MS         110
`define BCP_T_PROBE_PER_MS    55
`define BCP_T_CV_HOLD_MS      875
`define BCP_T_DECAY_MS        13125
`define BCP_CHARGE_TICK_PERIOD_TICK_MS     56000
`define BCP_T_BLANK_MS        300000
`define BCP_T_RATE_CHECK_MS   12000
`define BCP_T_RATE_HOLD_MS    168000
`define BCP_RATE_CHECKS       (`BCP_T_RATE_HOLD_MS / `BCP_T_RATE_CHECK_MS)
`define BCP_RATE_SCALE        (60000 / `BCP_T_RATE_CHECK_MS)
// ==========================================
// temperatures, 0.125 C per count
`define BCP_T_WIN_LO          0
`define BCP_T_WIN_HI          320
`define BCP_T_MAX             400
`define BCP_T_BAND1           40
`define BCP_T_BAND2           120
// rate thresholds, 1/128 C per minute
`define BCP_RATE_THR1         8'h26
`define BCP_RATE_THR2         8'h3A
`define BCP_RATE_THR3         8'h4D
// ==========================================
// status init byte fields and reset value
`define BCP_ST_SLEEP_PERMIT   5
`define BCP_ST_AUTO_START     4
`define BCP_ST_CHEMISTRY      3
`define BCP_STATUS_RST        8'h00
// ==========================================
// current averaging
`define BCP_CUR_SAMPLES       64
`define BCP_CUR_SHIFT         6
`define BCP_CUR_MAX           16383
`define BCP_CUR_MIN           (-16384)
`endif

// >>> verilog/bcp_pkg.sv
// Purpose: types of the charge and power controller
// Assumes: nothing
// Notes:   states are one-hot
package bcp_pkg;
	// ==========================================
	// states
	typedef enum logic [2:0] {
		BCP_PW_ACTIVE = 3'h1,
		BCP_PW_WIND   = 3'h2,
		BCP_PW_SLEEP  = 3'h4
	} bcp_power_type;

	typedef enum logic [4:0] {
		BCP_CH_IDLE = 5'h01,
		BCP_CH_PEND = 5'h02,
		BCP_CH_FAST = 5'h04,
		BCP_CH_HOLD = 5'h08,
		BCP_CH_REST = 5'h10
	} bcp_charge_type;

	// ==========================================
	// register state
	typedef struct packed {
		bcp_power_type       pw;
		bcp_charge_type      ch;
		logic                ld_status;
		logic                permit;
		logic                auto_st;
		logic                chem;
		logic                done;
		logic                chg_prev;
		logic [16:0]         pre;
		logic [11:0]         dq_ms;
		logic [13:0]         wind_ms;
		logic [6:0]          conv_ms;
		logic [5:0]          probe_ms;
		logic [11:0]         probe_cyc;
		logic [13:0]         phase_ms;
		logic [15:0]         tick_ms;
		logic [18:0]         fast_ms;
		logic [13:0]         rate_ms;
		logic [3:0]          rate_hits;
		logic [7:0]          rate_thr;
		logic signed [19:0]  temp_avg;
		logic signed [19:0]  temp_ref;
		logic [7:0]          ctr;
		logic                trickle_n;
		logic                fast_n;
		logic                cst_hi;
		logic                cst_lo;
	} bcp_core_type;

	typedef struct packed {
		logic signed [22:0]  sum;
		logic [5:0]          cnt;
		logic [14:0]         avg;
	} bcp_avg_type;
endpackage : bcp_pkg

// >>> verilog/bcp_cur_avg.sv
// Purpose: averaged signed current reading
// Assumes: one sense sample per 55 ms conversion
// Notes:   64 samples make one 3.52 s window
`timescale 1ns/100ps
`include "bcp_regs.svh"
module bcp_cur_avg (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               ce,
	// samples
	input  wire logic               run,
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] sense_input_a,
	input  wire logic signed [15:0] sense_input_b,
	// result
	output logic [14:0]             current_avg
);
	import bcp_pkg::*;

	bcp_avg_type        s;
	bcp_avg_type        next_s;
	logic signed [16:0] diff;
	logic signed [22:0] total;
	logic signed [16:0] mean;

	// ==========================================
	// accumulate and saturate
	always_comb begin
		next_s = s;
		// positive difference is charge current
		diff = 17'(sense_input_a) - 17'(sense_input_b);
		total = s.sum + 23'(diff);
		mean = 17'(total >>> `BCP_CUR_SHIFT);
		if (!run) begin
			// sleep drops a partial window
			next_s.sum = 23'sh0;
			next_s.cnt = 6'h0;
		end else if (sample_valid) begin
			if (s.cnt == 6'(`BCP_CUR_SAMPLES - 1)) begin
				next_s.sum = 23'sh0;
				next_s.cnt = 6'h0;
				if (mean > 17'sd`BCP_CUR_MAX)
					next_s.avg = 15'h3FFF;
				else if (mean < -17'sd16384)
					next_s.avg = 15'h4000;
				else
					next_s.avg = mean[14:0];
			end else begin
				next_s.sum = total;
				next_s.cnt = s.cnt + 6'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign current_avg = s.avg;
endmodule : bcp_cur_avg

// >>> verilog/bcp_charge_ctrl.sv
// Purpose: standalone charge controller with sleep and active modes
// Assumes: analog compares and conversions arrive as synchronous inputs
// Notes:   one ms prescaler paces all long timers
//
// Behaviour
// - sleep permitted, no auto-start: data low over 2 s stops charge, starts sleep
// - sleep permitted with auto-start: sleep waits until ongoing charge finishes
// - wake on data line high, or charger arrival with auto-start
// - sleep is reached within 11 s after the 2 s low detection
// - power-up starts in active mode
// - active mode measures and controls; sleep stops all activity
// - chemistry bit 0 picks lithium pulse, 1 picks NiMH rate charging
// - trickle gate low in active mode while charger present and battery below low threshold
// - trickle or fast charging shows state pair 0,1 unless done latched
// - fast charge starts on start command or charger arrival with auto-start
// - defer start outside 0..40 C, no charger, conversions invalid, low battery
// - fast gate low, pulsed high 27 us every 55 ms
// - charger loss or stop command raises fast gate; restart needs new start
// - completion raises gate, latches 1,1; status write clears latch
// - lithium: low under CV; at CV hold 875 ms, high until voltage decays
// - lithium ends when gate high time exceeds 13.125 s
// - NiMH rate threshold 0.30, 0.45 or 0.60 C/min from start temperature
// - NiMH blanks 5 min, then ends after 2.8 min sustained rise
// - over 50 C ends charging with state 1,1
// - timer loads at start, drops every 56 s, ends at zero, host may write
// - current is 15-bit signed 3.52 s average, saturating
// - positive sense difference a minus b means charging
// - status loads from init byte at power-up and on refresh
`timescale 1ns/100ps
`include "bcp_regs.svh"
module bcp_charge_ctrl #(
	parameter int unsigned MS_CYC = `BCP_MS_CYC
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               ce,
	// link and charger sensing
	input  wire logic               data_line_in,
	input  wire logic               charger_supply_in,
	// measurements
	input  wire logic               batt_below_lb,
	input  wire logic               batt_at_cv,
	input  wire logic signed [15:0] temp_code,
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] sense_input_a,
	input  wire logic signed [15:0] sense_input_b,
	// host commands and nonvolatile init bytes
	input  wire logic               start_charge_cmd,
	input  wire logic               stop_charge_cmd,
	input  wire logic               refresh_cmd,
	input  wire logic               status_wr,
	input  wire logic [7:0]         nv_status_init,
	input  wire logic [7:0]         nv_charge_time,
	input  wire logic               ctr_wr,
	input  wire logic [7:0]         ctr_wr_data,
	// gates
	output logic                    trickle_gate_n,
	output logic                    fast_charge_gate_n,
	// status
	output logic                    charge_state_hi,
	output logic                    charge_state_lo,
	output logic                    sleep_permit,
	output logic                    charge_auto_start,
	output logic                    chemistry_select,
	output logic [7:0]              charge_time_count,
	output logic                    active_mode,
	output logic [14:0]             current_avg
);
	import bcp_pkg::*;

	localparam bcp_core_type CORE_RST = '{
		pw:        BCP_PW_ACTIVE,
		ch:        BCP_CH_IDLE,
		ld_status: 1'b1,
		trickle_n: 1'b1,
		fast_n:    1'b1,
		default:   '0
	};

	// probe length follows the ms scale, never below one cycle
	localparam int unsigned PROBE_RAW = MS_CYC * `BCP_T_PROBE_US / `BCP_T_MS_US;
	localparam int unsigned PROBE_LEN = (PROBE_RAW == 0) ? 1 : PROBE_RAW;

	bcp_core_type       s;
	bcp_core_type       next_s;
	logic               ms_tick;
	logic               tick55;
	logic               dq_long;
	logic               busy;
	logic               next_busy;
	logic               wake;
	logic               abort;
	logic               init;
	logic               complete;
	logic               in_window;
	logic               conv_ok;
	logic signed [19:0] temp_scaled;
	logic signed [19:0] delta;
	logic signed [22:0] rate;

	// ==========================================
	// next state
	always_comb begin
		next_s = s;
		abort = 1'b0;
		complete = 1'b0;
		delta = 20'sh0;
		rate = 23'sh0;
		temp_scaled = {temp_code, 4'h0};

		// prescaler halts in sleep
		ms_tick = (s.pw != BCP_PW_SLEEP) && (s.pre == 17'(MS_CYC - 1));
		if (s.pw == BCP_PW_SLEEP)
			next_s.pre = 17'h0;
		else if (ms_tick)
			next_s.pre = 17'h0;
		else
			next_s.pre = s.pre + 17'h1;

		tick55 = ms_tick && (s.probe_ms == 6'(`BCP_T_PROBE_PER_MS - 1));
		if (tick55)
			next_s.probe_ms = 6'h0;
		else if (ms_tick)
			next_s.probe_ms = s.probe_ms + 6'h1;

		// status config byte
		if (s.ld_status || refresh_cmd) begin
			next_s.ld_status = 1'b0;
			next_s.permit = nv_status_init[`BCP_ST_SLEEP_PERMIT];
			next_s.auto_st = nv_status_init[`BCP_ST_AUTO_START];
			next_s.chem = nv_status_init[`BCP_ST_CHEMISTRY];
		end

		// ==========================================
		// data line low timer
		if (data_line_in)
			next_s.dq_ms = 12'h0;
		else if (ms_tick && s.dq_ms <= 12'(`BCP_T_DQ_LOW_MS))
			next_s.dq_ms = s.dq_ms + 12'h1;
		dq_long = s.dq_ms > 12'(`BCP_T_DQ_LOW_MS);

		busy = (s.ch == BCP_CH_FAST) || (s.ch == BCP_CH_HOLD) || (s.ch == BCP_CH_REST);
		// charger wake is an arrival; a level would bounce out of wind-down
		wake = data_line_in || (charger_supply_in && !s.chg_prev && s.auto_st);

		if (ms_tick && s.conv_ms < 7'(`BCP_T_CONV_MS))
			next_s.conv_ms = s.conv_ms + 7'h1;
		conv_ok = s.conv_ms >= 7'(`BCP_T_CONV_MS);

		// ==========================================
		// power modes
		case (s.pw)
			BCP_PW_ACTIVE: begin
				if (s.permit && dq_long) begin
					if (!s.auto_st || !busy) begin
						abort = 1'b1;
						next_s.pw = BCP_PW_WIND;
						next_s.wind_ms = 14'h0;
					end
				end
			end
			BCP_PW_WIND: begin
				abort = !wake;
				if (wake) begin
					next_s.pw = BCP_PW_ACTIVE;
				end else if (ms_tick) begin
					if (s.wind_ms == 14'(`BCP_T_WIND_MS - 1))
						next_s.pw = BCP_PW_SLEEP;
					else
						next_s.wind_ms = s.wind_ms + 14'h1;
				end
			end
			BCP_PW_SLEEP: begin
				abort = !wake;
				if (wake) begin
					// conversions restart after wake
					next_s.pw = BCP_PW_ACTIVE;
					next_s.conv_ms = 7'h0;
					next_s.dq_ms = 12'h0;
				end
			end
			default: begin
				next_s.pw = BCP_PW_ACTIVE;
			end
		endcase

		// ==========================================
		// temperature averaging for rate detection
		if (tick55)
			next_s.temp_avg = s.temp_avg + ((temp_scaled - s.temp_avg) >>> 3);

		in_window = (temp_code >= 16'sd`BCP_T_WIN_LO) && (temp_code <= 16'sd`BCP_T_WIN_HI);
		next_s.chg_prev = charger_supply_in;
		// a charger arrival also wakes, so it may start a charge from sleep
		init = ((s.pw == BCP_PW_ACTIVE) && start_charge_cmd)
			|| (charger_supply_in && !s.chg_prev && s.auto_st);

		// ==========================================
		// charge sequencing
		case (s.ch)
			BCP_CH_IDLE: begin
				if (init)
					next_s.ch = BCP_CH_PEND;
			end
			BCP_CH_PEND: begin
				if (stop_charge_cmd) begin
					next_s.ch = BCP_CH_IDLE;
				end else if (in_window && charger_supply_in && conv_ok
					&& !batt_below_lb) begin
					next_s.ch = BCP_CH_FAST;
					next_s.ctr = nv_charge_time;
					next_s.tick_ms = 16'h0;
					next_s.fast_ms = 19'h0;
					next_s.rate_ms = 14'h0;
					next_s.rate_hits = 4'h0;
					next_s.phase_ms = 14'h0;
					if (temp_code < 16'sd`BCP_T_BAND1)
						next_s.rate_thr = `BCP_RATE_THR1;
					else if (temp_code < 16'sd`BCP_T_BAND2)
						next_s.rate_thr = `BCP_RATE_THR2;
					else
						next_s.rate_thr = `BCP_RATE_THR3;
				end
			end
			BCP_CH_FAST: begin
				if (!s.chem && batt_at_cv) begin
					next_s.ch = BCP_CH_HOLD;
					next_s.phase_ms = 14'h0;
				end
			end
			BCP_CH_HOLD: begin
				if (ms_tick) begin
					if (s.phase_ms == 14'(`BCP_T_CV_HOLD_MS - 1)) begin
						next_s.ch = BCP_CH_REST;
						next_s.phase_ms = 14'h0;
					end else begin
						next_s.phase_ms = s.phase_ms + 14'h1;
					end
				end
			end
			BCP_CH_REST: begin
				if (s.phase_ms > 14'(`BCP_T_DECAY_MS)) begin
					complete = 1'b1;
				end else if (!batt_at_cv) begin
					next_s.ch = BCP_CH_HOLD;
					next_s.phase_ms = 14'h0;
				end else if (ms_tick) begin
					next_s.phase_ms = s.phase_ms + 14'h1;
				end
			end
			default: begin
				next_s.ch = BCP_CH_IDLE;
			end
		endcase

		// ==========================================
		// NiMH rate termination
		if (s.chem && s.ch == BCP_CH_FAST && ms_tick) begin
			if (s.fast_ms < 19'(`BCP_T_BLANK_MS)) begin
				// blanking keeps the reference fresh
				next_s.fast_ms = s.fast_ms + 19'h1;
				next_s.temp_ref = s.temp_avg;
			end else if (s.rate_ms == 14'(`BCP_T_RATE_CHECK_MS - 1)) begin
				next_s.rate_ms = 14'h0;
				delta = s.temp_avg - s.temp_ref;
				rate = 23'(delta) * 23'(`BCP_RATE_SCALE);
				next_s.temp_ref = s.temp_avg;
				if (rate >= $signed({15'h0, s.rate_thr})) begin
					next_s.rate_hits = s.rate_hits + 4'h1;
					if (s.rate_hits == 4'(`BCP_RATE_CHECKS - 1))
						complete = 1'b1;
				end else begin
					next_s.rate_hits = 4'h0;
				end
			end else begin
				next_s.rate_ms = s.rate_ms + 14'h1;
			end
		end

		// ==========================================
		// secondary terminations and charge timer
		if (busy) begin
			if (temp_code > 16'sd`BCP_T_MAX)
				complete = 1'b1;
			if (s.ctr == 8'h0)
				complete = 1'b1;
			if (ms_tick) begin
				if (s.tick_ms == 16'(`BCP_CHARGE_TICK_PERIOD_TICK_MS - 1)) begin
					next_s.tick_ms = 16'h0;
					next_s.ctr = s.ctr - 8'h1;
				end else begin
					next_s.tick_ms = s.tick_ms + 16'h1;
				end
			end
		end
		if (ctr_wr)
			next_s.ctr = ctr_wr_data;

		if (complete)
			next_s.ch = BCP_CH_IDLE;
		if (busy && (stop_charge_cmd || !charger_supply_in))
			next_s.ch = BCP_CH_IDLE;
		if (abort)
			next_s.ch = BCP_CH_IDLE;

		// completion set wins over a same-cycle status write
		if (status_wr)
			next_s.done = 1'b0;
		if (complete)
			next_s.done = 1'b1;

		// ==========================================
		// gates and state pair
		next_s.trickle_n = !((s.pw == BCP_PW_ACTIVE) && charger_supply_in
			&& batt_below_lb);

		if (next_s.ch != BCP_CH_FAST && next_s.ch != BCP_CH_HOLD)
			next_s.probe_cyc = 12'h0;
		else if (tick55)
			next_s.probe_cyc = 12'(PROBE_LEN);
		else if (s.probe_cyc != 12'h0)
			next_s.probe_cyc = s.probe_cyc - 12'h1;

		// gate is low only in bulk and hold, except while probing
		next_s.fast_n = !((next_s.ch == BCP_CH_FAST) || (next_s.ch == BCP_CH_HOLD))
			|| (next_s.probe_cyc != 12'h0);

		next_busy = (next_s.ch == BCP_CH_FAST) || (next_s.ch == BCP_CH_HOLD)
			|| (next_s.ch == BCP_CH_REST);
		next_s.cst_hi = next_s.done;
		next_s.cst_lo = next_s.done || next_busy || !next_s.trickle_n;
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			s <= CORE_RST;
		else if (ce)
			s <= next_s;
	end

	// ==========================================
	// current averaging
	bcp_cur_avg u_cur_avg (
		.clk_sys       (clk_sys),
		.nrst          (nrst),
		.ce            (ce),
		.run           (s.pw != BCP_PW_SLEEP),
		.sample_valid  (sample_valid),
		.sense_input_a (sense_input_a),
		.sense_input_b (sense_input_b),
		.current_avg   (current_avg)
	);

	assign trickle_gate_n = s.trickle_n;
	assign fast_charge_gate_n = s.fast_n;
	assign charge_state_hi = s.cst_hi;
	assign charge_state_lo = s.cst_lo;
	assign sleep_permit = s.permit;
	assign charge_auto_start = s.auto_st;
	assign chemistry_select = s.chem;
	assign charge_time_count = s.ctr;
	// one-hot, bit 0 is active
	assign active_mode = s.pw[0];
endmodule : bcp_charge_ctrl

// >>> tb/bcp_charge_props.sv
// Purpose: timing relations at the charge controller ports
// Assumes: ce low freezes all state, so checks pause with it
// Notes:   bound onto every bcp_charge_ctrl instance
`timescale 1ns/100ps
`include "bcp_regs.svh"
module bcp_charge_props (
	// clock and reset
	input wire logic               clk_sys,
	input wire logic               nrst,
	input wire logic               ce,
	// inputs
	input wire logic               data_line_in,
	input wire logic               charger_supply_in,
	input wire logic               batt_below_lb,
	input wire logic signed [15:0] temp_code,
	input wire logic               stop_charge_cmd,
	input wire logic               status_wr,
	input wire logic               ctr_wr,
	input wire logic [7:0]         ctr_wr_data,
	// outputs
	input wire logic               trickle_gate_n,
	input wire logic               fast_charge_gate_n,
	input wire logic               charge_state_hi,
	input wire logic               charge_state_lo,
	input wire logic [7:0]         charge_time_count,
	input wire logic               active_mode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst || !ce);
	// ========
	// gates and state pair
	a_done_gate:
	assert property (charge_state_hi |-> fast_charge_gate_n && charge_state_lo)
		else $error("done state while fast gate on");
	a_done_latch:
	assert property (charge_state_hi && !status_wr |=> charge_state_hi)
		else $error("done state lost without status write");
	a_stop_gate:
	assert property (stop_charge_cmd |=> fast_charge_gate_n)
		else $error("fast gate on after stop");
	a_unplug_gate:
	assert property (!charger_supply_in |=> fast_charge_gate_n)
		else $error("fast gate on without charger");
	a_hot_done:
	assert property (!fast_charge_gate_n && temp_code > `BCP_T_MAX |=> charge_state_hi)
		else $error("over temperature did not end charge");
	a_trickle_on:
	assert property (charger_supply_in && batt_below_lb && active_mode |=> !trickle_gate_n)
		else $error("trickle gate off on low cell");
	a_trickle_off:
	assert property (!batt_below_lb |=> trickle_gate_n)
		else $error("trickle gate on above threshold");
	a_fast_state:
	assert property (!fast_charge_gate_n |-> charge_state_lo && !charge_state_hi)
		else $error("fast charging without state 01");
	// ========
	// power modes and timer
	a_sleep_idle:
	assert property (!active_mode |-> fast_charge_gate_n && trickle_gate_n)
		else $error("gate on outside active mode");
	a_wake_data:
	assert property (!active_mode && data_line_in |-> ##[1:2] active_mode)
		else $error("no wake on data line high");
	a_ctr_write:
	assert property (ctr_wr |=> charge_time_count == $past(ctr_wr_data))
		else $error("timer write not taken");
endmodule : bcp_charge_props

bind bcp_charge_ctrl bcp_charge_props bcp_charge_props_inst (
	.clk_sys, .nrst, .ce, .data_line_in, .charger_supply_in, .batt_below_lb,
	.temp_code, .stop_charge_cmd, .status_wr, .ctr_wr, .ctr_wr_data,
	.trickle_gate_n, .fast_charge_gate_n, .charge_state_hi, .charge_state_lo,
	.charge_time_count, .active_mode
);

// >>> tb/bcp_charger_model.sv
// Purpose: charge source and cell seen by the charge controller
// Assumes: cell climbs one step a cycle while plugged in and either gate is on
// Notes:   the bench pulls the plug itself
`timescale 1ns/100ps
module bcp_charger_model #(
	parameter logic [7:0] LB_LEVEL = 8'h20
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic nrst,
	// bench control
	input  wire logic plug_in,
	// gates from the controller
	input  wire logic trickle_gate_n,
	input  wire logic fast_charge_gate_n,
	// sensed levels
	output logic      charger_supply_in,
	output logic      batt_below_lb
);
	logic [7:0] level;
	// supply drops at once, so the controller must notice removal itself
	assign charger_supply_in = plug_in;
	assign batt_below_lb     = level < LB_LEVEL;
	always_ff @(posedge clk_sys) begin
		if (!nrst)
			level <= 8'h00;
		else if (plug_in && !(trickle_gate_n && fast_charge_gate_n) && level != 8'hFF)
			level <= level + 8'h01;
	end
endmodule : bcp_charger_model

// >>> tb/tb.sv
// Purpose: self-checking bench for the charge and power controller
// Assumes: one ms shortened to two clocks
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
module tb;
	import bcp_pkg::*;
	logic               clk_sys, nrst, ce, data_line_in, plug, batt_at_cv;
	logic               start_charge_cmd, stop_charge_cmd, refresh_cmd, status_wr;
	logic               ctr_wr, sample_valid, charger_supply_in, batt_below_lb;
	logic               trickle_gate_n, fast_charge_gate_n, charge_state_hi;
	logic               charge_state_lo, sleep_permit, charge_auto_start;
	logic               chemistry_select, active_mode;
	logic signed [15:0] temp_code, sense_input_a, sense_input_b;
	logic [7:0]         nv_status_init, nv_charge_time, ctr_wr_data, charge_time_count;
	logic [14:0]        current_avg;
	int                 error_cnt, checks;
	logic [15:0]        cur_a [3] = '{16'h0064, 16'h0000, 16'h7FFF};
	logic [15:0]        cur_b [3] = '{16'h0028, 16'h0032, 16'h8000};
	logic [14:0]        cur_exp [3] = '{15'h003C, 15'h7FCE, 15'h3FFF};

	bcp_charge_ctrl #(.MS_CYC(2)) bcp_charge_ctrl_inst (
		.clk_sys, .nrst, .ce, .data_line_in, .charger_supply_in, .batt_below_lb,
		.batt_at_cv, .temp_code, .sample_valid, .sense_input_a, .sense_input_b,
		.start_charge_cmd, .stop_charge_cmd, .refresh_cmd, .status_wr,
		.nv_status_init, .nv_charge_time, .ctr_wr, .ctr_wr_data, .trickle_gate_n,
		.fast_charge_gate_n, .charge_state_hi, .charge_state_lo, .sleep_permit,
		.charge_auto_start, .chemistry_select, .charge_time_count, .active_mode,
		.current_avg
	);
	bcp_charger_model bcp_charger_model_inst (
		.clk_sys, .nrst, .plug_in(plug), .trickle_gate_n, .fast_charge_gate_n,
		.charger_supply_in, .batt_below_lb
	);

	// ========
	// helpers
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_val(input logic [14:0] got, input logic [14:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk_val
	task automatic results;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// ========
	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		error_cnt++;
		results();
	end

	// ========
	// sequence
	initial begin
		{error_cnt, checks} = '0;
		{nrst, ce, data_line_in, plug, batt_at_cv} = 5'b01100;
		{start_charge_cmd, stop_charge_cmd, refresh_cmd, status_wr} = 4'h0;
		{ctr_wr, sample_valid, ctr_wr_data} = 10'h000;
		{temp_code, sense_input_a, sense_input_b} = {16'h00A0, 32'h0};
		nv_status_init = 8'h00;
		nv_charge_time = 8'h5A;
		tick(2);
		chk_bit(active_mode, 1'b1);
		chk_bit(fast_charge_gate_n & trickle_gate_n, 1'b1);
		nrst = 1'b1;
		tick(240);
		chk_bit(chemistry_select, 1'b0);
		for (int w = 0; w < 3; w++) begin
			sense_input_a = cur_a[w];
			sense_input_b = cur_b[w];
			repeat (64) begin
				pulse(sample_valid);
				tick(1);
			end
			tick(3);
			chk_val(current_avg, cur_exp[w]);
		end
		// trickle until the cell crosses the low threshold
		plug = 1'b1;
		tick(2);
		chk_bit(trickle_gate_n, 1'b0);
		chk_val({charge_state_hi, charge_state_lo}, 15'h1);
		tick(40);
		chk_bit(trickle_gate_n, 1'b1);
		// start deferred by a warm cell, then fast charge
		temp_code = 16'h014A;
		pulse(start_charge_cmd);
		tick(3);
		chk_bit(fast_charge_gate_n, 1'b1);
		temp_code = 16'h00A0;
		tick(2);
		chk_bit(fast_charge_gate_n, 1'b0);
		chk_val({7'h0, charge_time_count}, 15'h5A);
		ctr_wr_data = 8'h07;
		pulse(ctr_wr);
		chk_val({7'h0, charge_time_count}, 15'h07);
		temp_code = 16'h0191;
		tick(2);
		chk_val({charge_state_hi, charge_state_lo, fast_charge_gate_n}, 15'h7);
		temp_code = 16'h00A0;
		tick(5);
		chk_bit(charge_state_hi, 1'b1);
		pulse(status_wr);
		chk_bit(charge_state_hi, 1'b0);
		// stop command and charger removal both need a fresh start
		pulse(start_charge_cmd);
		tick(2);
		pulse(stop_charge_cmd);
		chk_bit(fast_charge_gate_n, 1'b1);
		pulse(start_charge_cmd);
		tick(2);
		plug = 1'b0;
		tick(2);
		chk_bit(fast_charge_gate_n, 1'b1);
		plug = 1'b1;
		tick(20);
		chk_bit(fast_charge_gate_n, 1'b1);
		// auto start with sleep permitted
		nv_status_init = 8'h38;
		pulse(refresh_cmd);
		tick(2);
		chk_val({sleep_permit, charge_auto_start, chemistry_select}, 15'h7);
		plug = 1'b0;
		tick(2);
		plug = 1'b1;
		tick(4);
		chk_bit(fast_charge_gate_n, 1'b0);
		data_line_in = 1'b0;
		tick(4100);
		chk_val({active_mode, charge_state_lo}, 15'h3);
		temp_code = 16'h0191;
		tick(5);
		chk_val({active_mode, charge_state_hi}, 15'h1);
		temp_code = 16'h00A0;
		tick(22100);
		pulse(start_charge_cmd);
		tick(3);
		chk_bit(fast_charge_gate_n, 1'b1);
		plug = 1'b0;
		tick(2);
		plug = 1'b1;
		tick(3);
		chk_bit(active_mode, 1'b1);
		pulse(status_wr);
		tick(200);
		chk_bit(fast_charge_gate_n, 1'b1);
		tick(40);
		chk_bit(fast_charge_gate_n, 1'b0);
		pulse(stop_charge_cmd);
		// sleep without auto start halts the charge at once
		data_line_in = 1'b1;
		nv_status_init = 8'h20;
		pulse(refresh_cmd);
		pulse(start_charge_cmd);
		tick(2);
		chk_bit(fast_charge_gate_n, 1'b0);
		data_line_in = 1'b0;
		// lithium pulse region while the data line low time runs
		batt_at_cv = 1'b1;
		tick(1700);
		chk_bit(fast_charge_gate_n, 1'b0);
		tick(42);
		chk_bit(fast_charge_gate_n, 1'b1);
		tick(58);
		chk_bit(fast_charge_gate_n, 1'b1);
		batt_at_cv = 1'b0;
		tick(2);
		chk_bit(fast_charge_gate_n, 1'b0);
		tick(2188);
		chk_bit(active_mode, 1'b1);
		tick(20);
		chk_val({active_mode, fast_charge_gate_n}, 15'h1);
		data_line_in = 1'b1;
		tick(3);
		chk_bit(active_mode, 1'b1);
		results();
	end
endmodule : tb
